// ==== rtl/fab_host.sv ====
/*
 * Host controller that drives an asynchronous 16-bit flash over its pins.
 * Assumes the flash data bus comes back unsynchronised; it is resampled here.
 */
// Notes on behaviour
// - Output enable may trail chip select; host asserts both together here.
// - Write cycle at least 90 ns, low pulse 50 ns, high 20 ns.
// - Write enable stays high at least 1 us after reset pin release.
// - Chip select falls 10 ns before write enable and rises after it.
// - Address and data held stable through strobe rise, setup 50 ns.
// - Supply and unlock levels are kept outside; a level output reports need.
// - In chip-select strobed writes write enable falls before chip select.
// - Chip-select strobe low at least 50 ns, high at least 20 ns.
// - Chip select stays high at least 1 us after reset pin release.
// - Reset pin held low at least 100 ns when a reset is requested.
// - Reset pin held low after system reset, covering power-up settling.
// - Command sequences are issued by the user as successive bus writes.
// - A read may follow a write immediately with no recovery gap.
`timescale 1ns/100ps
module fab_host #(
    parameter int ABORT_CYC = fab_pkg::C_ABORT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire fab_pkg::fab_req_t req,
    input wire logic reset_req,
    input wire logic busy_op,
    input wire logic [fab_pkg::DW-1:0] dq_in,
    output fab_pkg::fab_pins_t pins,
    output logic req_ready,
    output logic rd_valid,
    output logic [fab_pkg::DW-1:0] rd_data,
    output logic supply_hold
);
    // ****************************************************************
    // Checks and state
    // ****************************************************************
    // The whole recovery wait must fit the counter, or the count would wrap.
    if (ABORT_CYC < 1 || fab_pkg::C_RST_REC + fab_pkg::C_RST_OUT + ABORT_CYC
            >= (1 << fab_pkg::CNT_W)) begin : g_bad_abort
        $error("ABORT_CYC out of range");
    end

    typedef enum logic [3:0] {
        S_RST_LOW, S_RST_WAIT, S_IDLE, S_RD_ACC, S_RD_CAP, S_FLOAT,
        S_WR_SETUP, S_WR_LOW, S_WR_HIGH
    } fab_state_t;

    fab_state_t state_q;
    logic [fab_pkg::CNT_W-1:0] cnt_q;
    logic [fab_pkg::DW-1:0] dq_s1_q;
    logic [fab_pkg::DW-1:0] dq_s2_q;
    logic ce_strb_q;
    logic busy_q;

    // Data pins are asynchronous to us, so two flops before use.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // Tracks an operation in progress so supply_hold stays up while it runs.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_op;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Synchroniser delay adds two cycles of margin on every read capture.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_RST_LOW;
            cnt_q <= '0;
            pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                      we_n: 1'b1, reset_powerdown_n: 1'b0};
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            ce_strb_q <= 1'b0;
            supply_hold <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (state_q)
                S_RST_LOW: begin
                    pins.reset_powerdown_n <= 1'b0;
                    req_ready <= 1'b0;
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_RST_LOW - 1)) begin
                        pins.reset_powerdown_n <= 1'b1;
                        cnt_q <= '0;
                        state_q <= S_RST_WAIT;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_RST_WAIT: begin
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_RST_REC + fab_pkg::C_RST_OUT
                                                 + ABORT_CYC - 1)) begin
                        cnt_q <= '0;
                        req_ready <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_IDLE: begin
                    cnt_q <= '0;
                    if (reset_req) begin
                        req_ready <= 1'b0;
                        pins.reset_powerdown_n <= 1'b0;
                        state_q <= S_RST_LOW;
                    end else if (req_valid) begin
                        req_ready <= 1'b0;
                        pins.addr <= req.addr;
                        pins.dq_out <= req.data;
                        ce_strb_q <= req.ce_strobe;
                        if (req.write) begin
                            // data driven ahead of strobe; the non-strobe select falls first
                            pins.dq_oe <= 1'b1;
                            pins.ce_n <= req.ce_strobe;
                            pins.we_n <= !req.ce_strobe;
                            supply_hold <= 1'b1;
                            state_q <= S_WR_SETUP;
                        end else begin
                            pins.ce_n <= 1'b0;
                            pins.oe_n <= 1'b0;
                            state_q <= S_RD_ACC;
                        end
                    end
                end
                S_RD_ACC: begin
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_RD_ACCESS + 1)) begin
                        cnt_q <= '0;
                        state_q <= S_RD_CAP;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_RD_CAP: begin
                    rd_data <= dq_s2_q;
                    rd_valid <= 1'b1;
                    pins.ce_n <= 1'b1;
                    pins.oe_n <= 1'b1;
                    state_q <= S_FLOAT;
                end
                S_FLOAT: begin
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_FLOAT - 1)) begin
                        cnt_q <= '0;
                        req_ready <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_WR_SETUP: begin
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_CE_SETUP - 1)) begin
                        cnt_q <= '0;
                        pins.ce_n <= 1'b0;
                        pins.we_n <= 1'b0;
                        state_q <= S_WR_LOW;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_WR_LOW: begin
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_STB_LOW - 1)) begin
                        cnt_q <= '0;
                        if (ce_strb_q) begin
                            pins.ce_n <= 1'b1;
                        end else begin
                            pins.we_n <= 1'b1;
                        end
                        state_q <= S_WR_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_WR_HIGH: begin
                    pins.ce_n <= 1'b1;
                    pins.we_n <= 1'b1;
                    pins.dq_oe <= 1'b0;
                    if (cnt_q >= fab_pkg::CNT_W'(fab_pkg::C_STB_HIGH - 1)) begin
                        cnt_q <= '0;
                        req_ready <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= S_RST_LOW;
                end
            endcase
            // supply held while the device reports an operation.
            if (state_q == S_IDLE && !req_valid && !busy_q) begin
                supply_hold <= 1'b0;
            end
        end
    end
endmodule // fab_host

// ==== rtl/fab_pkg.sv ====
/*
 * Constants, timing figures and carrier types for the flash bus host controller.
 * Assumes a single system clock whose period is given here in nanoseconds.
 */
package fab_pkg;
    // ****************************************************************
    // Clock and timing figures
    // ****************************************************************
    localparam int CLK_NS = 100;
    localparam int T_RD_ACCESS_NS = 90;
    localparam int T_OE_ACCESS_NS = 50;
    localparam int T_CE_FLOAT_NS = 55;
    localparam int T_OE_FLOAT_NS = 20;
    localparam int T_RST_OUT_NS = 600;
    localparam int T_WR_CYCLE_NS = 90;
    localparam int T_STB_LOW_NS = 50;
    localparam int T_STB_HIGH_NS = 20;
    localparam int T_CE_SETUP_NS = 10;
    localparam int T_RST_LOW_NS = 100;
    localparam int T_RST_REC_US = 1;
    localparam int T_ABORT_US = 22;

    // Minimum times round up to whole cycles, never below one.
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int C_RD_ACCESS = cyc_up(T_RD_ACCESS_NS);
    localparam int C_OE_ACCESS = cyc_up(T_OE_ACCESS_NS);
    localparam int C_FLOAT = cyc_up(T_CE_FLOAT_NS);
    localparam int C_STB_LOW = cyc_up(T_STB_LOW_NS);
    localparam int C_STB_HIGH = cyc_up(T_STB_HIGH_NS);
    localparam int C_CE_SETUP = cyc_up(T_CE_SETUP_NS);
    localparam int C_RST_LOW = cyc_up(T_RST_LOW_NS + T_RST_LOW_NS);
    localparam int C_RST_OUT = cyc_up(T_RST_OUT_NS);
    localparam int C_RST_REC = cyc_up(T_RST_REC_US * 1000);
    localparam int C_ABORT = cyc_up(T_ABORT_US * 1000);
    localparam int CNT_W = 16;

    // ****************************************************************
    // Command carrier
    // ****************************************************************
    localparam int AW = 19;
    localparam int DW = 16;

    typedef struct packed {
        logic write;
        logic ce_strobe;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } fab_req_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_powerdown_n;
    } fab_pins_t;
endpackage

// ==== sim/fab_flash_model.sv ====
/* Behavioural flash array on the far side of the host pins.
   Assumes the pins carrier; only 16 words are modelled. */
`timescale 1ns/100ps
module fab_flash_model #(
    parameter int ACC_NS = 90
) (
    input wire logic sys_clk,
    input wire fab_pkg::fab_pins_t pins,
    output logic [15:0] dq_in
);
    // ********************************
    // Array, read path and write latch
    // ********************************
    logic [15:0] mem [16];
    logic [15:0] last_q = 16'h0000;
    logic drive;
    logic we_n;
    logic ce_n;
    int up_cyc = 0;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    // Strobes as plain signals, so the latch below sees clean edges.
    assign we_n = pins.we_n;
    assign ce_n = pins.ce_n;
    // cycles since the reset pin went high; reads before the delay see junk.
    always @(posedge sys_clk) up_cyc <= pins.reset_powerdown_n ? up_cyc + 1 : 0;
    assign drive = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n
        && up_cyc >= fab_pkg::C_RST_OUT;
    assign #(ACC_NS) dq_in = drive ? mem[pins.addr[3:0]] : ~last_q;
    // A released bus shows the inverse of the last word, so stale data never passes.
    always @(posedge sys_clk) if (drive) last_q <= mem[pins.addr[3:0]];
    // The closing edge of whichever strobe rises first latches the word.
    always @(posedge we_n or posedge ce_n) begin
        if ((!we_n || !ce_n) && pins.dq_oe) mem[pins.addr[3:0]] <= pins.dq_out;
    end
endmodule // fab_flash_model

// ==== sim/fab_host_assertions.sv ====
/* Pin timing checker for the flash bus host controller.
   Assumes it is bound into fab_host and sees only its ports. */
`timescale 1ns/100ps
module fab_host_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic reset_req,
    input wire fab_pkg::fab_pins_t pins,
    input wire logic req_ready,
    input wire logic rd_valid
);
    // ********************************
    // Recovery counter and properties
    // ********************************
    logic [4:0] rec_q;
    // Cycles since the reset pin went high; saturates so it never wraps.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rec_q <= '0;
        else if (!pins.reset_powerdown_n) rec_q <= '0;
        else if (rec_q != 5'h1f) rec_q <= rec_q + 5'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence we_pulse_s;
        (!pins.we_n && $stable(pins.addr)) ##1 (pins.we_n && $stable(pins.dq_out));
    endsequence
    sequence ce_pulse_s;
        ##1 ($rose(pins.ce_n) && $stable(pins.addr)) ##1 ($rose(pins.we_n) && !pins.dq_oe);
    endsequence
    AST_WE_WRITE: assert property ($fell(pins.we_n) && !pins.ce_n |-> we_pulse_s)
        else $error("write enable pulse malformed");
    AST_CE_WRITE: assert property ($fell(pins.ce_n) && !pins.we_n |-> ce_pulse_s)
        else $error("chip select write pulse malformed");
    AST_WE_ORDER: assert property ($fell(pins.we_n) |-> pins.ce_n || !$past(pins.ce_n))
        else $error("strobe order broken");
    AST_REC_WAIT: assert property ($fell(pins.we_n) || $fell(pins.ce_n) |-> rec_q >= 5'h0a)
        else $error("strobe too soon after reset pin");
    AST_RD_SEL: assert property ($fell(pins.oe_n) |-> $fell(pins.ce_n) && !pins.dq_oe)
        else $error("read select or bus contention");
    // Select stays low for the access wait plus capture, then data comes with release.
    AST_RD_TIME: assert property ($fell(pins.oe_n) |->
        (!pins.oe_n && !rd_valid) [*4] ##1 (pins.oe_n && rd_valid))
        else $error("read access window wrong");
    AST_RD_FLOAT: assert property ($rose(rd_valid) |=> req_ready)
        else $error("not ready after read");
    AST_TAKE: assert property (req_ready && req_valid |=> !req_ready)
        else $error("request not taken");
    AST_RST_REQ: assert property (req_ready && reset_req |-> ##[1:3] !pins.reset_powerdown_n)
        else $error("reset pin not lowered");
    AST_RST_LOW: assert property ($rose(pins.reset_powerdown_n) |->
        !$past(pins.reset_powerdown_n, 2) ##0 !req_ready [*8])
        else $error("reset pin pulse too short");
endmodule // fab_host_assertions
bind fab_host fab_host_assertions chk_i (.sys_clk, .rst_n, .req_valid, .reset_req, .pins,
    .req_ready, .rd_valid);

// ==== sim/flash_async_bus_timing_test.sv ====
/* Self-checking bench for the flash bus host controller.
   Assumes fab_pkg, fab_host, the flash model and the checker. */
`timescale 1ns/100ps
module flash_async_bus_timing_test;
    // ********************************
    // Stimulus, tasks and scenarios
    // ********************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    fab_pkg::fab_req_t req = '0;
    logic reset_req = 1'b0;
    logic busy_op = 1'b0;
    logic [15:0] dq_in;
    fab_pkg::fab_pins_t pins;
    logic req_ready;
    logic rd_valid;
    logic supply_hold;
    logic [15:0] rd_data;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    fab_host #(.ABORT_CYC(2)) dut (.sys_clk, .rst_n, .req_valid, .req, .reset_req, .busy_op,
        .dq_in, .pins, .req_ready, .rd_valid, .rd_data, .supply_hold);
    fab_flash_model flash (.sys_clk, .pins, .dq_in);
    initial forever #50 sys_clk = ~sys_clk;
    // A hang counts as a mismatch; the tests need well under two hundred cycles.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        chk("ready", 16'h0001, {15'h0000, req_ready});
    endtask
    task automatic issue(input logic w, input logic ce, input logic [3:0] a, input logic [15:0] d);
        int n;
        wait_ready(n);
        req = '{write: w, ce_strobe: ce, addr: {15'h0000, a}, data: d};
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask
    task automatic read_chk(input logic [3:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        issue(1'b0, 1'b0, a, 16'h0000);
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk("read cycles", 16'h0004, n[15:0]);
        chk("read data", exp, rd_data);
    endtask
    task automatic t_power();
        int n;
        wait_ready(n);
        chk("recovery wait", 16'h0001, {15'h0000, n >= 18});
        chk("reset pin", 16'h0001, {15'h0000, pins.reset_powerdown_n});
    endtask
    task automatic t_writes();
        issue(1'b1, 1'b0, 4'h3, 16'h5a3c);
        read_chk(4'h3, 16'h5a3c);
        issue(1'b1, 1'b1, 4'hf, 16'hffff);
        issue(1'b1, 1'b0, 4'h0, 16'ha5c3);
        read_chk(4'hf, 16'hffff);
        read_chk(4'h0, 16'ha5c3);
    endtask
    task automatic t_busy();
        issue(1'b1, 1'b0, 4'h7, 16'h0040);
        issue(1'b1, 1'b1, 4'h7, 16'h1234);
        busy_op = 1'b1;
        read_chk(4'h7, 16'h1234);
        chk("supply hold", 16'h0001, {15'h0000, supply_hold});
        busy_op = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("supply drop", 16'h0000, {15'h0000, supply_hold});
    endtask
    task automatic t_reset();
        int n;
        wait_ready(n);
        reset_req = 1'b1;
        @(negedge sys_clk);
        reset_req = 1'b0;
        chk("reset low", 16'h0000, {15'h0000, pins.reset_powerdown_n});
        @(negedge sys_clk);
        chk("reset held", 16'h0000, {15'h0000, pins.reset_powerdown_n});
        @(negedge sys_clk);
        chk("reset high", 16'h0001, {15'h0000, pins.reset_powerdown_n});
        read_chk(4'hf, 16'hffff);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        t_power();
        t_writes();
        t_busy();
        t_reset();
        final_report();
    end
endmodule // flash_async_bus_timing_test
